/* File: shared/io_output_pkg.sv */
// Constants, field layout and types shared by the output path design
package io_output_pkg;

	// ********************************
	// Register map
	// ********************************
	localparam logic [31:0] CONFIG_ADDR  = 32'h0000_0000;
	localparam logic [31:0] STATUS_ADDR  = 32'h0000_0004;
	localparam int          CONFIG_WIDTH = 16;
	localparam logic [15:0] CONFIG_RESET = 16'h0000;

	// Configuration fields
	localparam int CFG_OUT_INV  = 0;
	localparam int CFG_T_INV    = 1;
	localparam int CFG_REGISTER = 2;
	localparam int CFG_INIT_SET = 3;
	localparam int CFG_CLK_INV  = 4;
	localparam int CFG_CE_CONN  = 5;
	localparam int CFG_T_CONN   = 6;
	localparam int CFG_FAST     = 7;
	localparam int CFG_MODE_LO  = 8;
	localparam int CFG_FUNC_LO  = 10;
	localparam int CFG_INV_A    = 12;
	localparam int CFG_INV_B    = 13;
	localparam int CFG_GF_NODE  = 14;
	localparam int CFG_GF_INV   = 15;

	// Status fields
	localparam int ST_FF_Q    = 0;
	localparam int ST_DRIVE   = 1;
	localparam int ST_GFLOAT  = 2;
	localparam int ST_RUN     = 3;
	localparam int ST_OUT_CLK = 4;

	// ********************************
	// Bus and pin constants
	// ********************************
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic       HRESP_OKAY = 1'h0;
	localparam int         PIN_OUTCLK = 0;
	localparam int         PIN_GFLOAT = 1;
	localparam int         PIN_COUNT  = 2;
	localparam logic       INIT_CLEAR = 1'h0;

	// ********************************
	// Types
	// ********************************
	typedef enum logic [1:0] {
		PATH_DIRECT = 2'b00,
		PATH_MUX    = 2'b01,
		PATH_FUNC   = 2'b10
	} path_type;

	typedef enum logic [1:0] {
		FUNC_PASS = 2'b00,
		FUNC_AND  = 2'b01,
		FUNC_OR   = 2'b10,
		FUNC_XOR  = 2'b11
	} func_type;

	typedef enum logic [1:0] {
		SS_WAIT = 2'b00,
		SS_SOFT = 2'b01,
		SS_RUN  = 2'b10
	} startup_type;

endpackage

/* File: src/output_cell_ff.sv */
// Output storage flip-flop with global initialisation and load strobe
`timescale 1ns/100ps

module output_cell_ff import io_output_pkg::*; (
	input  logic ref_clk,
	input  logic rst,
	input  logic init_pulse,
	input  logic init_set,
	input  logic load,
	input  logic d,
	output logic q
);

	// ********************************
	// Storage
	// ********************************
	// Initialisation beats clock, enable and data alike
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q <= INIT_CLEAR;
		end else if (init_pulse) begin
			q <= init_set;
		end else if (load) begin
			q <= d;
		end
	end

endmodule

/* File: src/io_output_path.sv */
// Output path of one configurable I/O cell with an AHB-Lite configuration port
//
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps

module io_output_path import io_output_pkg::*; (
	input  logic        ref_clk,
	input  logic        rst,
	input  logic        hsel,
	input  logic [31:0] haddr,
	input  logic [1:0]  htrans,
	input  logic        hwrite,
	input  logic [2:0]  hsize,
	input  logic [31:0] hwdata,
	input  logic        hready,
	output logic [31:0] hrdata,
	output logic        hreadyout,
	output logic        hresp,
	input  logic        out_a,
	input  logic        out_b,
	input  logic        t_in,
	input  logic        ce_in,
	input  logic        out_clk_pin,
	input  logic        global_init_pulse,
	input  logic        global_output_float_pin,
	input  logic        global_output_float_node,
	input  logic        scan_extest,
	input  logic        startup_done,
	output logic        pad_out,
	output logic        pad_oe,
	output logic        slew_fast
);

	// ********************************
	// Functions
	// ********************************
	function automatic logic hit(input logic [31:0] a, input logic [31:0] t);
		return a == t;
	endfunction

	function automatic logic fgen(input func_type op, input logic a, input logic b);
		logic r;
		r = a;
		unique case (op)
			FUNC_PASS: r = a;
			FUNC_AND:  r = a & b;
			FUNC_OR:   r = a | b;
			FUNC_XOR:  r = a ^ b;
		endcase
		return r;
	endfunction

	// ********************************
	// Declarations
	// ********************************
	logic [CONFIG_WIDTH-1:0] cfg_reg;
	logic                    wr_pend_reg;
	logic [31:0]             wr_addr_reg;
	logic [31:0]             status_word;
	logic [CONFIG_WIDTH-1:0] cfg_view;
	logic                    addr_phase;
	logic [PIN_COUNT-1:0]    pin_raw;
	logic [PIN_COUNT-1:0]    s1_reg;
	logic [PIN_COUNT-1:0]    s2_reg;
	logic [PIN_COUNT-1:0]    s3_reg;
	logic [PIN_COUNT-1:0]    filt_reg;
	logic [PIN_COUNT-1:0]    pin_new;
	startup_type             state_reg;
	path_type                mode_sel;
	func_type                func_sel;
	logic                    ok_lvl;
	logic                    ok_edge;
	logic                    ce_eff;
	logic                    ff_load;
	logic                    ff_q;
	logic                    raw_data;
	logic                    data_pol;
	logic                    pad_data;
	logic                    t_local;
	logic                    g_src;
	logic                    g_active;
	logic                    drive_on;

	// ********************************
	// AHB-Lite slave
	// ********************************
	// Zero wait states; only whole-word transfers are acted on
	assign addr_phase = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);

	// A read right behind a write to the same word sees the new value
	assign cfg_view = (wr_pend_reg && hit(wr_addr_reg, CONFIG_ADDR)) ?
		hwdata[CONFIG_WIDTH-1:0] : cfg_reg;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 32'h0000_0000;
			hrdata      <= 32'h0000_0000;
			hreadyout   <= 1'b1;
			hresp       <= HRESP_OKAY;
		end else begin
			wr_pend_reg <= addr_phase & hwrite;
			if (addr_phase) begin
				wr_addr_reg <= haddr;
			end
			if (addr_phase && !hwrite) begin
				if (hit(haddr, CONFIG_ADDR)) begin
					hrdata <= {{(32-CONFIG_WIDTH){1'b0}}, cfg_view};
				end else if (hit(haddr, STATUS_ADDR)) begin
					hrdata <= status_word;
				end else begin
					hrdata <= 32'h0000_0000;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cfg_reg <= CONFIG_RESET;
		end else if (wr_pend_reg && hit(wr_addr_reg, CONFIG_ADDR)) begin
			cfg_reg <= hwdata[CONFIG_WIDTH-1:0];
		end
	end

	always_comb begin
		status_word             = 32'h0000_0000;
		status_word[ST_FF_Q]    = ff_q;
		status_word[ST_DRIVE]   = pad_oe;
		status_word[ST_GFLOAT]  = g_active;
		status_word[ST_RUN]     = (state_reg == SS_RUN);
		status_word[ST_OUT_CLK] = filt_reg[PIN_OUTCLK];
	end

	// ********************************
	// Pin synchronisers
	// ********************************
	// A level counts only once the second and third stages agree
	assign pin_raw = {global_output_float_pin, out_clk_pin};

	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					s1_reg[gi]   <= 1'b0;
					s2_reg[gi]   <= 1'b0;
					s3_reg[gi]   <= 1'b0;
					filt_reg[gi] <= 1'b0;
				end else begin
					s1_reg[gi] <= pin_raw[gi];
					s2_reg[gi] <= s1_reg[gi];
					s3_reg[gi] <= s2_reg[gi];
					if (s2_reg[gi] == s3_reg[gi]) begin
						filt_reg[gi] <= s2_reg[gi];
					end
				end
			end
			assign pin_new[gi] = (s2_reg[gi] == s3_reg[gi]) ? s2_reg[gi] : filt_reg[gi];
		end
	endgenerate

	// ********************************
	// Output flip-flop
	// ********************************
	// Rising edge by default, falling when the clock is inverted
	assign ok_lvl  = filt_reg[PIN_OUTCLK];
	assign ok_edge = (pin_new[PIN_OUTCLK] != ok_lvl) &&
		(pin_new[PIN_OUTCLK] != cfg_reg[CFG_CLK_INV]);
	assign ce_eff  = cfg_reg[CFG_CE_CONN] ? ce_in : 1'b1;
	assign ff_load = ok_edge & ce_eff;

	output_cell_ff u_ff (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.init_pulse (global_init_pulse),
		.init_set   (cfg_reg[CFG_INIT_SET]),
		.load       (ff_load),
		.d          (data_pol),
		.q          (ff_q)
	);

	// ********************************
	// Data path
	// ********************************
	assign mode_sel = path_type'(cfg_reg[CFG_MODE_LO +: 2]);
	assign func_sel = func_type'(cfg_reg[CFG_FUNC_LO +: 2]);

	// The fast output clock input is the mux select and the critical input
	always_comb begin
		raw_data = out_a;
		unique case (mode_sel)
			PATH_DIRECT: raw_data = out_a;
			PATH_MUX:    raw_data = ok_lvl ? out_b : out_a;
			PATH_FUNC:   raw_data = fgen(func_sel, out_a ^ cfg_reg[CFG_INV_A],
				ok_lvl ^ cfg_reg[CFG_INV_B]);
			default:     raw_data = out_a;
		endcase
	end

	assign data_pol = raw_data ^ cfg_reg[CFG_OUT_INV];
	assign pad_data = cfg_reg[CFG_REGISTER] ? ff_q : data_pol;

	// ********************************
	// Three-state control
	// ********************************
	assign t_local  = (cfg_reg[CFG_T_CONN] ? t_in : 1'b0) ^ cfg_reg[CFG_T_INV];
	assign g_src    = cfg_reg[CFG_GF_NODE] ? global_output_float_node :
		filt_reg[PIN_GFLOAT];
	assign g_active = (g_src ^ cfg_reg[CFG_GF_INV]) & ~scan_extest;
	assign drive_on = ~t_local & ~g_active & (state_reg != SS_WAIT);

	// ********************************
	// Start-up sequencing
	// ********************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= SS_WAIT;
		end else begin
			unique case (state_reg)
				SS_WAIT: if (startup_done) begin
					state_reg <= SS_SOFT;
				end
				SS_SOFT: if (drive_on) begin
					state_reg <= SS_RUN;
				end
				SS_RUN:  state_reg <= SS_RUN;
			endcase
		end
	end

	// ********************************
	// Pad drivers
	// ********************************
	// Registered pins cost one cycle of latency but never glitch
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pad_out   <= 1'b0;
			pad_oe    <= 1'b0;
			slew_fast <= 1'b0;
		end else begin
			pad_oe    <= drive_on;
			pad_out   <= drive_on ? pad_data : 1'b0;
			slew_fast <= (state_reg == SS_RUN) & cfg_reg[CFG_FAST];
		end
	end

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence soft_first_s;
		state_reg == SS_SOFT && drive_on;
	endsequence

	sequence soft_slow_s;
		pad_oe && !slew_fast;
	endsequence

	soft_start_a: assert property (soft_first_s |=> soft_slow_s ##1
		(slew_fast == $past(cfg_reg[CFG_FAST])))
		else $error("first activation not slow then configured");
	slew_slow_a: assert property ((state_reg == SS_RUN && !cfg_reg[CFG_FAST])
		|=> !slew_fast) else $error("slow slew not honoured");
	float_force_a: assert property (g_active |=> !pad_oe)
		else $error("global float did not float pad");
	extest_keep_a: assert property ((scan_extest && !t_local && state_reg == SS_RUN)
		|=> pad_oe) else $error("extest lost driver");
	tstate_float_a: assert property (t_local |=> (!pad_oe && !pad_out))
		else $error("three-state did not float pad");
	t_default_a: assert property ((!cfg_reg[CFG_T_CONN] && !cfg_reg[CFG_T_INV] &&
		!g_active && state_reg == SS_RUN) |=> pad_oe) else $error("default driver off");
	init_value_a: assert property (global_init_pulse |=>
		(ff_q == $past(cfg_reg[CFG_INIT_SET]))) else $error("init value wrong");
	ff_hold_a: assert property ((!ff_load && !global_init_pulse) |=> $stable(ff_q))
		else $error("flop changed without load");
	ff_load_a: assert property ((ok_edge && ce_eff && !global_init_pulse) |=>
		(ff_q == $past(data_pol))) else $error("flop missed load");
	ce_default_a: assert property ((!cfg_reg[CFG_CE_CONN] && ok_edge &&
		!global_init_pulse) |=> (ff_q == $past(data_pol))) else $error("enable default low");
	open_drain_a: assert property ((mode_sel == PATH_DIRECT && !cfg_reg[CFG_REGISTER] &&
		!cfg_reg[CFG_OUT_INV] && !out_a && cfg_reg[CFG_T_CONN] && !cfg_reg[CFG_T_INV] &&
		!g_active && state_reg == SS_RUN) |=> (!pad_out && pad_oe == !$past(t_in)))
		else $error("open-drain behaviour wrong");
	mux_select_a: assert property ((mode_sel == PATH_MUX && drive_on &&
		!cfg_reg[CFG_REGISTER] && !cfg_reg[CFG_OUT_INV]) |=>
		(pad_out == $past(ok_lvl ? out_b : out_a))) else $error("mux selected wrong input");
	func_and_a: assert property ((mode_sel == PATH_FUNC && func_sel == FUNC_AND &&
		cfg_reg[CFG_INV_A] && !cfg_reg[CFG_INV_B] && drive_on && !cfg_reg[CFG_REGISTER] &&
		!cfg_reg[CFG_OUT_INV]) |=> (pad_out == $past(!out_a & ok_lvl)))
		else $error("function output wrong");

endmodule

/* File: testbench/pad_partner.sv */
// Board-side pad load: a pull-up holds the line whenever the cell floats it
`timescale 1ns/100ps

module pad_partner (
	input  logic pad_out,
	input  logic pad_oe,
	output logic pad_level
);
	// A float must read as the pull-up, never as the last driven value
	assign pad_level = pad_oe ? pad_out : 1'b1;
endmodule

/* File: testbench/io_output_path_tb.sv */
// Self-checking bench for the I/O output path
`timescale 1ns/100ps

module io_output_path_tb import io_output_pkg::*;;
	// ********************************
	// Signals
	// ********************************
	typedef struct {int due; int which; logic [31:0] exp;} note_type;
	logic        ref_clk = 0, rst = 1, hsel = 0, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 0;
	logic        hreadyout, hresp, pad_out, pad_oe, slew_fast, pad_level;
	logic        out_a = 0, out_b = 0, t_in = 0, ce_in = 0, out_clk_pin = 0;
	logic        init_p = 0, gf_pin = 0, gf_node = 0, extest = 0, su_done = 0;
	note_type    notes[$];
	note_type    cur;
	int          ncyc = 0, errors = 0, check_count = 0;

	always #50 ref_clk = ~ref_clk;

	io_output_path u_io_output_path (
		.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .out_a(out_a),
		.out_b(out_b), .t_in(t_in), .ce_in(ce_in), .out_clk_pin(out_clk_pin),
		.global_init_pulse(init_p), .global_output_float_pin(gf_pin),
		.global_output_float_node(gf_node), .scan_extest(extest),
		.startup_done(su_done), .pad_out(pad_out), .pad_oe(pad_oe),
		.slew_fast(slew_fast)
	);

	pad_partner u_pad_partner (.pad_out(pad_out), .pad_oe(pad_oe), .pad_level(pad_level));

	// ********************************
	// Checking
	// ********************************
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic note(int which, logic [31:0] exp, int n);
		notes.push_back('{ncyc + n + 1, which, exp});
	endtask

	task automatic padchk(logic lvl, logic oe, int n);
		note(1, lvl, n);
		note(2, oe, n);
		repeat (n) @(posedge ref_clk);
	endtask

	// Sampled mid-cycle so every edge update has landed
	always @(negedge ref_clk) begin
		ncyc++;
		while (notes.size() > 0 && notes[0].due <= ncyc) begin
			cur = notes.pop_front();
			case (cur.which)
			0: check("hrdata", hrdata, cur.exp);
			1: check("pad", {31'h0, pad_level}, cur.exp);
			2: check("pad_oe", {31'h0, pad_oe}, cur.exp);
			3: check("slew_fast", {31'h0, slew_fast}, cur.exp);
			default: check("hready_resp", {30'h0, hreadyout, hresp}, cur.exp);
			endcase
		end
	end

	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ********************************
	// Drivers
	// ********************************
	task automatic bus(logic wr, logic [31:0] a, logic [31:0] d, logic [2:0] sz,
		logic [31:0] ex);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= sz;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		// Read data still stands after the data phase; the next read address is a cycle away
		note(4, {30'h0, 1'b1, HRESP_OKAY}, 0);
		if (!wr)
			note(0, ex, 0);
	endtask

	// Waits long enough for the three-stage clock synchroniser
	task automatic fstep(logic clk, logic a, logic ce, logic exp);
		out_clk_pin <= clk;
		out_a <= a;
		ce_in <= ce;
		padchk(exp, 1'b1, 9);
	endtask

	task automatic pulse(logic exp);
		init_p <= 1'b1;
		@(posedge ref_clk);
		init_p <= 1'b0;
		padchk(exp, 1'b1, 3);
	endtask

	// ********************************
	// Scenarios
	// ********************************
	initial begin
		logic [31:0] cfg;
		logic        a, b, t, oe, f;
		void'($urandom(32'hc167ff92));
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		note(3, 0, 0);
		bus(0, CONFIG_ADDR, 0, HSIZE_WORD, {16'h0, CONFIG_RESET});
		bus(1, CONFIG_ADDR, 32'hffff_0080, HSIZE_WORD, 0);
		bus(1, CONFIG_ADDR, 32'h0000_0001, 3'h1, 0);
		bus(0, 32'h0000_0008, 0, HSIZE_WORD, 32'h0);
		bus(0, CONFIG_ADDR, 0, HSIZE_WORD, 32'h0000_0080);
		padchk(1'b1, 1'b0, 3);
		su_done <= 1'b1;
		note(3, 0, 2);
		padchk(1'b0, 1'b1, 2);
		note(3, 1, 1);
		@(posedge ref_clk);
		// Random polarity and three-state combinations on the direct path
		for (int i = 0; i < 24; i++) begin
			cfg = $urandom() & 32'h0000_00c3;
			bus(1, CONFIG_ADDR, cfg, HSIZE_WORD, 0);
			a = 1'($urandom());
			t = 1'($urandom());
			out_a <= a;
			t_in <= t;
			oe = !((cfg[CFG_T_CONN] & t) ^ cfg[CFG_T_INV]);
			padchk(oe ? a ^ cfg[CFG_OUT_INV] : 1'b1, oe, 1);
			note(3, cfg[CFG_FAST], 0);
		end
		out_a <= 1'b0;
		t_in <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			bus(1, CONFIG_ADDR, {16'h0, i[0], 15'h4000}, HSIZE_WORD, 0);
			gf_node <= i[1];
			extest <= i[2];
			oe = !((i[1] ^ i[0]) & !i[2]);
			padchk(!oe, oe, 1);
		end
		gf_node <= 1'b0;
		extest <= 1'b0;
		bus(1, CONFIG_ADDR, 0, HSIZE_WORD, 0);
		gf_pin <= 1'b1;
		padchk(1'b1, 1'b0, 5);
		bus(0, STATUS_ADDR, 0, HSIZE_WORD, (32'h1 << ST_GFLOAT) | (32'h1 << ST_RUN));
		gf_pin <= 1'b0;
		padchk(1'b0, 1'b1, 5);
		// Mux and two-input function, output clock as the second input
		for (int i = 0; i < 64; i++) begin
			a = 1'($urandom());
			b = 1'($urandom());
			cfg = {20'h0, 2'(i), 10'h0} | 32'(1'($urandom()));
			cfg |= i[5] ? 32'h0000_0100 : (32'h0000_0200 | {i[3:2], 12'h0});
			bus(1, CONFIG_ADDR, cfg, HSIZE_WORD, 0);
			out_a <= a;
			out_b <= b;
			out_clk_pin <= i[4];
			case (i[1:0])
			0: f = a ^ i[2];
			1: f = (a ^ i[2]) & (i[4] ^ i[3]);
			2: f = (a ^ i[2]) | (i[4] ^ i[3]);
			default: f = (a ^ i[2]) ^ (i[4] ^ i[3]);
			endcase
			if (i[5])
				f = i[4] ? b : a;
			padchk(f ^ cfg[CFG_OUT_INV], 1'b1, 5);
		end
		// Registered path: init value, enable, active edge choice
		bus(1, CONFIG_ADDR, 32'h0000_002c, HSIZE_WORD, 0);
		pulse(1'b1);
		fstep(1'b0, 1'b0, 1'b1, 1'b1);
		fstep(1'b1, 1'b0, 1'b0, 1'b1);
		fstep(1'b0, 1'b0, 1'b0, 1'b1);
		fstep(1'b1, 1'b0, 1'b1, 1'b0);
		bus(1, CONFIG_ADDR, 32'h0000_003c, HSIZE_WORD, 0);
		fstep(1'b1, 1'b1, 1'b1, 1'b0);
		fstep(1'b0, 1'b1, 1'b1, 1'b1);
		bus(1, CONFIG_ADDR, 32'h0000_0014, HSIZE_WORD, 0);
		pulse(1'b0);
		fstep(1'b1, 1'b1, 1'b0, 1'b0);
		fstep(1'b0, 1'b1, 1'b0, 1'b1);
		bus(0, STATUS_ADDR, 0, HSIZE_WORD,
			(32'h1 << ST_FF_Q) | (32'h1 << ST_DRIVE) | (32'h1 << ST_RUN));
		report_and_stop();
	end

	// Run needs about 670 cycles; this bound is far beyond that
	initial begin
		#(100 * 8000);
		errors++;
		report_and_stop();
	end
endmodule
